// file: logic/pio_pkg.sv
package pio_pkg;
    // module addresses on the core i/o bus
    localparam logic [3:0] ADR_PORT1 = 4'h1;
    localparam logic [3:0] ADR_PORT2 = 4'h2;
    localparam logic [3:0] ADR_SYS = 4'h3;
    localparam logic [3:0] ADR_PORT4 = 4'h4;
    localparam logic [3:0] ADR_PORT5 = 4'h5;
    localparam logic [3:0] ADR_PORT6 = 4'h6;
    localparam logic [3:0] ADR_TIMER12_SUBPORT_DATA = 4'h7;
    localparam logic [3:0] ADR_AUXSW = 4'h8;
    localparam logic [3:0] ADR_SERBUF = 4'h9;
    localparam logic [3:0] ADR_SERSC = 4'hA;
    localparam logic [3:0] ADR_TIMER3_SUBPORT_DATA = 4'hB;
    localparam logic [3:0] ADR_T3CTL = 4'hC;
    localparam logic [3:0] ADR_VMON = 4'hF;
    // subport indices
    localparam logic [3:0] SUB_T2CMP2 = 4'h5;
    localparam logic [3:0] SUB_T3CMP1 = 4'h4;
    localparam logic [3:0] SUB_T3CMP2 = 4'h5;
    localparam int T12_CNT = 11;
    localparam int T3_CNT = 6;
    // subports 6 and 7 of the timer 1/2 bank are reserved
    localparam logic [10:0] T12_USED = 11'h73F;
    // values after reset, undefined bits taken as zero
    localparam logic [3:0] RST_PORT1 = 4'h9;
    localparam logic [3:0] RST_PORT6 = 4'h9;
    localparam logic [3:0] RST_NIB = 4'hF;
    localparam logic [7:0] RST_BYTE = 8'hFF;
    localparam logic [3:0] RST_SYSCFG = 4'hB;
    localparam logic [3:0] RST_SERSC = 4'hB;
    localparam logic [3:0] RST_T3CTL = 4'h0;
    localparam logic [7:0] RST_TXBUF = 8'h00;
    localparam logic [3:0] RST_AUXSW = 4'hF;
    localparam logic [7:0] RST_T12 [T12_CNT] = '{
        8'h00, 8'h0F, 8'h0F, 8'h00, 8'h0F, 8'hFF,
        8'h00, 8'h00, 8'h0F, 8'h07, 8'h0F};
    localparam logic [7:0] RST_T3 [T3_CNT] = '{
        8'h0F, 8'h0F, 8'h00, 8'h00, 8'hFF, 8'hFF};
    // pin synchroniser
    localparam int PIN_BITS = 20;
    localparam logic [19:0] RST_PINS = 20'h00000;
endpackage : pio_pkg

// file: logic/pio_addr_map.sv
`timescale 1ns/100ps
// Contract
// - addr 1 port1 data RW, reset 1xx1, reads pins
// - addr 2 port2 data RW, reset 1111, pins
// - addr 2 aux port2 direction, write-only, 1111
// - addr 4 aux port4 control byte, 0xFF
// - addr 5 aux port5 control byte, 0xFF
// - addr 5 port5 data RW, 1111, pins
// - addr 6 port6 data RW, 1xx1, pins
// - addr 7 writes timer 1/2 subport bank
// - subport 0 timer2 control, reset 0000
// - subport 5 timer2 compare two byte, 0xFF
// - subport 9 timer1 control two, x111
// - addr 9 write loads serial tx buffer
// - addr 9 read returns serial rx buffer
// - addr A serial status/control RW, 1x11
// - addr B timer3 subport bank read/write
// - timer3 sub 4: write compare, read capture
// - addr C timer3 control, write-only, 0000
// - timer3 status readable, x000
// - addr F voltage monitor control, 1111
// - aux switch write selects next aux access
// - first OUT sets subport, next accesses it
// - byte registers take two nibble transfers
// - low nibble first, high nibble second
module pio_addr_map (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // core i/o bus
    input wire logic ioWrStb,
    input wire logic ioRdStb,
    input wire logic [3:0] ioAddr,
    input wire logic [3:0] ioWrData,
    output logic [3:0] ioRdData,
    output logic ioRdValid,
    // port pins, asynchronous
    input wire logic [3:0] port1Pins,
    input wire logic [3:0] port2Pins,
    input wire logic [3:0] port4Pins,
    input wire logic [3:0] port5Pins,
    input wire logic [3:0] port6Pins,
    // peripheral state, same clock
    input wire logic [7:0] serRxBuf,
    input wire logic [3:0] serStatus,
    input wire logic [7:0] t3Capture,
    input wire logic [3:0] t3Status,
    // port registers
    output logic [3:0] port1Data,
    output logic port1Drive,
    output logic [3:0] port2Data,
    output logic [3:0] port2Dir,
    output logic [3:0] port4Data,
    output logic [7:0] port4Ctl,
    output logic [3:0] port5Data,
    output logic [7:0] port5Ctl,
    output logic [3:0] port6Data,
    output logic [3:0] port6Ctl,
    // system registers
    output logic [3:0] sysCfg,
    output logic [3:0] clkMgmt,
    output logic wdogKick,
    output logic [3:0] vmonCtl,
    // serial interface registers
    output logic [7:0] serTxBuf,
    output logic serTxLoad,
    output logic [3:0] serCtl1,
    output logic [3:0] serStatCtl,
    output logic [3:0] serCtl2,
    // timer registers
    output logic [7:0] t12Regs [pio_pkg::T12_CNT],
    output logic [7:0] t3Regs [pio_pkg::T3_CNT],
    output logic [3:0] t3Ctl
);

    // access sequencing state
    logic [3:0] auxAddr_q;      // module picked by aux switch
    logic auxValid_q;           // aux selection pending
    logic [3:0] subAddr7_q;     // timer 1/2 subaddress
    logic [3:0] subAddrB_q;     // timer 3 subaddress
    logic [1:0] subArmed_q;     // subaddress loaded, data next
    logic byteHi_q;             // high nibble of a byte is next
    logic [3:0] byteLo_q;       // staged low nibble
    // register storage
    logic [3:0] p1Data_q, p2Data_q, p2Dir_q, p4Data_q, p5Data_q;
    logic [3:0] p6Data_q, p6Ctl_q, sysCfg_q, clkMgmt_q, vmon_q;
    logic [3:0] serCtl1_q, serSc_q, serCtl2_q, t3Ctl_q, rdData_q;
    logic [7:0] p4Ctl_q, p5Ctl_q, txBuf_q;
    logic p1Drive_q;            // 1 = port1 driving
    logic wdogKick_q, txLoad_q, rdValid_q;
    logic [7:0] t12_q [pio_pkg::T12_CNT];
    logic [7:0] t3_q [pio_pkg::T3_CNT];
    // pin synchroniser stages
    logic [19:0] pinS1_q;       // first stage, read by second only
    logic [19:0] pinS2_q, pinS3_q;
    logic [19:0] pinF_q;        // accepted pin levels
    logic [7:0] rdVal;          // selected read source

    // any bus access this cycle
    wire acc = ioWrStb | ioRdStb;
    wire isAuxSw = ioAddr == pio_pkg::ADR_AUXSW;
    // aux decode applies only where the aux address matches
    wire auxHit = auxValid_q && ioAddr == auxAddr_q;
    wire isSub7 = ioAddr == pio_pkg::ADR_TIMER12_SUBPORT_DATA;
    wire isSubB = ioAddr == pio_pkg::ADR_TIMER3_SUBPORT_DATA;
    wire isSub = isSub7 | isSubB;
    wire subArmed = isSub7 ? subArmed_q[0] : subArmed_q[1];
    wire [3:0] subAddr = isSub7 ? subAddr7_q : subAddrB_q;
    // first OUT to an unarmed bank carries the subaddress
    wire subAddrWr = ioWrStb && isSub && !subArmed;
    wire subIdle = isSub && !subArmed;
    wire t12Hit = isSub7 && subArmed;
    wire t3Hit = isSubB && subArmed;
    wire t3Sub4 = t3Hit && subAddr == pio_pkg::SUB_T3CMP1;
    wire t3Sub5 = t3Hit && subAddr == pio_pkg::SUB_T3CMP2;
    wire t2Sub5 = t12Hit && subAddr == pio_pkg::SUB_T2CMP2;
    wire auxByte = auxHit && (ioAddr == pio_pkg::ADR_PORT4
        || ioAddr == pio_pkg::ADR_PORT5);
    wire serByte = !auxHit && ioAddr == pio_pkg::ADR_SERBUF;
    // byte-wide targets need two transfers
    wire isByte = auxByte | serByte | t2Sub5 | t3Sub4 | t3Sub5;
    wire lastNib = !isByte || byteHi_q;
    // end of a data access: single nibble or second of a byte
    wire seqEnd = acc && lastNib && !subIdle && !isAuxSw;
    wire wrDone = ioWrStb && lastNib && !subIdle && !isAuxSw;
    wire wrPrim = wrDone && !auxHit;
    wire wrAux = wrDone && auxHit;
    // assembled write value, low nibble staged first
    wire [7:0] wrByte = {ioWrData, byteLo_q};
    wire [7:0] wrVal = isByte ? wrByte : {4'h0, ioWrData};
    wire rdPrim = ioRdStb && !auxHit;

    // primary and aux write enables
    wire wrP1 = wrPrim && ioAddr == pio_pkg::ADR_PORT1;
    wire wrP2 = wrPrim && ioAddr == pio_pkg::ADR_PORT2;
    wire wrP2Dir = wrAux && ioAddr == pio_pkg::ADR_PORT2;
    wire wrSys = wrPrim && ioAddr == pio_pkg::ADR_SYS;
    wire wrCm = wrAux && ioAddr == pio_pkg::ADR_SYS;
    wire wrP4 = wrPrim && ioAddr == pio_pkg::ADR_PORT4;
    wire wrP4Ctl = wrAux && ioAddr == pio_pkg::ADR_PORT4;
    wire wrP5 = wrPrim && ioAddr == pio_pkg::ADR_PORT5;
    wire wrP5Ctl = wrAux && ioAddr == pio_pkg::ADR_PORT5;
    wire wrP6 = wrPrim && ioAddr == pio_pkg::ADR_PORT6;
    wire wrP6Ctl = wrAux && ioAddr == pio_pkg::ADR_PORT6;
    wire wrTx = wrPrim && ioAddr == pio_pkg::ADR_SERBUF;
    wire wrSc1 = wrAux && ioAddr == pio_pkg::ADR_SERBUF;
    wire wrSsc = wrPrim && ioAddr == pio_pkg::ADR_SERSC;
    wire wrSc2 = wrAux && ioAddr == pio_pkg::ADR_SERSC;
    wire wrT3c = wrPrim && ioAddr == pio_pkg::ADR_T3CTL;
    wire wrVm = wrPrim && ioAddr == pio_pkg::ADR_VMON;
    wire wrT12 = wrDone && t12Hit;
    wire wrT3 = wrDone && t3Hit;
    wire rdP1 = rdPrim && ioAddr == pio_pkg::ADR_PORT1;
    wire rdKick = rdPrim && ioAddr == pio_pkg::ADR_SYS;

    // aux switch: remember module, drop after its access
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            auxAddr_q <= pio_pkg::RST_AUXSW;
            auxValid_q <= 1'b0;
        end else if (ioWrStb && isAuxSw) begin
            auxAddr_q <= ioWrData;
            auxValid_q <= 1'b1;
        end else if (seqEnd && auxHit) begin
            auxValid_q <= 1'b0;
        end
    end

    // subaddress registers of both banks
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            subAddr7_q <= 4'h0;
            subAddrB_q <= 4'h0;
            subArmed_q <= 2'b00;
        end else if (subAddrWr) begin
            // a read of an unarmed bank leaves it unarmed
            if (isSub7) begin
                subAddr7_q <= ioWrData;
                subArmed_q[0] <= 1'b1;
            end else begin
                subAddrB_q <= ioWrData;
                subArmed_q[1] <= 1'b1;
            end
        end else if (seqEnd && isSub) begin
            // back to subaddress phase after the data access
            subArmed_q <= subArmed_q & (isSub7 ? 2'b10 : 2'b01);
        end
    end

    // nibble sequencing for byte-wide registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            byteHi_q <= 1'b0;
        end else if (acc && isByte && !subIdle) begin
            byteHi_q <= !byteHi_q;
        end else if (acc) begin
            // any other access abandons a half-done byte
            byteHi_q <= 1'b0;
        end
    end

    // stage the low nibble until the high one arrives
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            byteLo_q <= 4'h0;
        end else if (ioWrStb && isByte && !byteHi_q) begin
            byteLo_q <= ioWrData;
        end
    end

    // port 1: data latch and automatic direction
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            p1Data_q <= pio_pkg::RST_PORT1;
            p1Drive_q <= 1'b0;
        end else if (wrP1) begin
            // only bits 0 and 3 exist on this port
            p1Data_q <= ioWrData & 4'h9;
            p1Drive_q <= 1'b1;
        end else if (rdP1) begin
            p1Drive_q <= 1'b0;
        end
    end

    // port 2 data and direction
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            p2Data_q <= pio_pkg::RST_NIB;
            p2Dir_q <= pio_pkg::RST_NIB;
        end else begin
            if (wrP2) p2Data_q <= ioWrData;
            if (wrP2Dir) p2Dir_q <= ioWrData;
        end
    end

    // system configuration and clock management
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sysCfg_q <= pio_pkg::RST_SYSCFG;
            clkMgmt_q <= pio_pkg::RST_NIB;
            wdogKick_q <= 1'b0;
        end else begin
            if (wrSys) sysCfg_q <= ioWrData;
            if (wrCm) clkMgmt_q <= ioWrData;
            // a primary read of the system address restarts the watchdog
            wdogKick_q <= rdKick;
        end
    end

    // ports 4 and 5, control registers are byte wide
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            p4Data_q <= pio_pkg::RST_NIB;
            p4Ctl_q <= pio_pkg::RST_BYTE;
            p5Data_q <= pio_pkg::RST_NIB;
            p5Ctl_q <= pio_pkg::RST_BYTE;
        end else begin
            if (wrP4) p4Data_q <= ioWrData;
            if (wrP4Ctl) p4Ctl_q <= wrVal;
            if (wrP5) p5Data_q <= ioWrData;
            if (wrP5Ctl) p5Ctl_q <= wrVal;
        end
    end

    // port 6 data and control
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            p6Data_q <= pio_pkg::RST_PORT6;
            p6Ctl_q <= pio_pkg::RST_NIB;
        end else begin
            if (wrP6) p6Data_q <= ioWrData & 4'h9;
            if (wrP6Ctl) p6Ctl_q <= ioWrData;
        end
    end

    // serial interface registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            txBuf_q <= pio_pkg::RST_TXBUF;
            txLoad_q <= 1'b0;
            serCtl1_q <= pio_pkg::RST_NIB;
            serSc_q <= pio_pkg::RST_SERSC;
            serCtl2_q <= pio_pkg::RST_NIB;
        end else begin
            if (wrTx) txBuf_q <= wrVal;
            // load strobe follows the high nibble only
            txLoad_q <= wrTx;
            if (wrSc1) serCtl1_q <= ioWrData;
            if (wrSsc) serSc_q <= ioWrData;
            if (wrSc2) serCtl2_q <= ioWrData;
        end
    end

    // timer 3 control and voltage monitor
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            t3Ctl_q <= pio_pkg::RST_T3CTL;
            vmon_q <= pio_pkg::RST_NIB;
        end else begin
            if (wrT3c) t3Ctl_q <= ioWrData;
            if (wrVm) vmon_q <= ioWrData;
        end
    end

    // timer 1/2 subport bank, reserved entries never load
    for (genvar i = 0; i < pio_pkg::T12_CNT; i++) begin : g_t12
        wire hit = wrT12 && subAddr == 4'(i) && pio_pkg::T12_USED[i];
        always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
                t12_q[i] <= pio_pkg::RST_T12[i];
            end else if (hit) begin
                t12_q[i] <= wrVal;
            end
        end
        assign t12Regs[i] = t12_q[i];
    end

    // timer 3 subport bank, subports 6 to F fall through
    for (genvar i = 0; i < pio_pkg::T3_CNT; i++) begin : g_t3
        wire hit = wrT3 && subAddr == 4'(i);
        always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
                t3_q[i] <= pio_pkg::RST_T3[i];
            end else if (hit) begin
                t3_q[i] <= wrVal;
            end
        end
        assign t3Regs[i] = t3_q[i];
    end

    // pins: three stages, a level counts once 2 and 3 agree
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pinS1_q <= pio_pkg::RST_PINS;
            pinS2_q <= pio_pkg::RST_PINS;
            pinS3_q <= pio_pkg::RST_PINS;
            pinF_q <= pio_pkg::RST_PINS;
        end else begin
            pinS1_q <= {port6Pins, port5Pins, port4Pins,
                port2Pins, port1Pins};
            pinS2_q <= pinS1_q;
            pinS3_q <= pinS2_q;
            // take agreeing bits, hold disagreeing ones
            pinF_q <= (pinS2_q & pinS3_q)
                | (pinF_q & (pinS2_q | pinS3_q));
        end
    end

    // read source selection
    always_comb begin
        rdVal = 8'h00;
        if (subIdle || isAuxSw) begin
            rdVal = 8'h00;
        end else if (auxHit) begin
            // only clock management is readable among aux regs
            if (ioAddr == pio_pkg::ADR_SYS) rdVal = {4'h0, clkMgmt_q};
        end else if (t3Sub4) begin
            rdVal = t3Capture;
        end else if (!isSub) begin
            case (ioAddr)
                pio_pkg::ADR_PORT1:
                    rdVal = {4'h0, pinF_q[3], 2'b00, pinF_q[0]};
                pio_pkg::ADR_PORT2: rdVal = {4'h0, pinF_q[7:4]};
                pio_pkg::ADR_PORT4: rdVal = {4'h0, pinF_q[11:8]};
                pio_pkg::ADR_PORT5: rdVal = {4'h0, pinF_q[15:12]};
                pio_pkg::ADR_PORT6:
                    rdVal = {4'h0, pinF_q[19], 2'b00, pinF_q[16]};
                pio_pkg::ADR_SERBUF: rdVal = serRxBuf;
                pio_pkg::ADR_SERSC: rdVal = {4'h0, serStatus};
                pio_pkg::ADR_T3CTL:
                    rdVal = {5'h00, t3Status[2:0]};
                default: rdVal = 8'h00;
            endcase
        end
    end
    // nibble picked from a byte source by sequence position
    wire [3:0] rdNib = (isByte && byteHi_q) ? rdVal[7:4] : rdVal[3:0];
    // read data register, held until the next read
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdData_q <= 4'h0;
            rdValid_q <= 1'b0;
        end else begin
            rdValid_q <= ioRdStb;
            if (ioRdStb) rdData_q <= rdNib;
        end
    end
    // outputs straight from the registers
    assign ioRdData = rdData_q, ioRdValid = rdValid_q;
    assign port1Data = p1Data_q, port1Drive = p1Drive_q;
    assign port2Data = p2Data_q, port2Dir = p2Dir_q;
    assign port4Data = p4Data_q, port4Ctl = p4Ctl_q;
    assign port5Data = p5Data_q, port5Ctl = p5Ctl_q;
    assign port6Data = p6Data_q, port6Ctl = p6Ctl_q;
    assign sysCfg = sysCfg_q, clkMgmt = clkMgmt_q;
    assign wdogKick = wdogKick_q, vmonCtl = vmon_q;
    assign serTxBuf = txBuf_q, serTxLoad = txLoad_q;
    assign serCtl1 = serCtl1_q, serStatCtl = serSc_q;
    assign serCtl2 = serCtl2_q, t3Ctl = t3Ctl_q;

endmodule : pio_addr_map

// file: dv/pio_addr_map_properties.sv
`timescale 1ns/100ps
module pio_addr_map_chk (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // core bus
    input wire logic ioWrStb,
    input wire logic ioRdStb,
    input wire logic [3:0] ioAddr,
    input wire logic [3:0] ioWrData,
    input wire logic [3:0] ioRdData,
    input wire logic ioRdValid,
    // watched registers
    input wire logic [3:0] port1Data,
    input wire logic port1Drive,
    input wire logic [3:0] port2Data,
    input wire logic [3:0] port2Dir,
    input wire logic [7:0] port5Ctl,
    input wire logic [3:0] t3Ctl,
    input wire logic [3:0] vmonCtl,
    input wire logic serTxLoad
);
    // one domain, so clock and reset are given once
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    // one out nibble to a module address
    sequence s_wr(logic [3:0] a);
        ioWrStb && ioAddr == a;
    endsequence
    // aux switch pointed at module m
    sequence s_sel(logic [3:0] m);
        ioWrStb && ioAddr == 4'h8 && ioWrData == m;
    endsequence
    property p_rdValid;
        ioRdStb |=> ioRdValid;
    endproperty
    property p_rdHold;
        !ioRdStb |=> $stable(ioRdData) && !ioRdValid;
    endproperty
    property p_t3Ctl;
        s_wr(4'hC) |=> t3Ctl == $past(ioWrData);
    endproperty
    property p_vmon;
        s_wr(4'hF) |=> vmonCtl == $past(ioWrData);
    endproperty
    // bits 1 and 2 have no pin behind them
    property p_port1;
        s_wr(4'h1) |=> port1Drive &&
            port1Data == {$past(ioWrData[3]), 2'b00, $past(ioWrData[0])};
    endproperty
    // aux nibble must leave the primary register alone
    property p_aux2;
        s_sel(4'h2) ##1 s_wr(4'h2) |=>
            port2Dir == $past(ioWrData) && $stable(port2Data);
    endproperty
    property p_aux5;
        s_sel(4'h5) ##1 s_wr(4'h5) ##1 s_wr(4'h5) |=>
            port5Ctl == {$past(ioWrData), $past(ioWrData, 2)};
    endproperty
    property p_txLoad;
        serTxLoad |-> $past(ioWrStb) && $past(ioAddr) == 4'h9;
    endproperty
    a_rdValid: assert property (p_rdValid)
        else $error("read answer missing");
    a_rdHold: assert property (p_rdHold)
        else $error("read data moved without a read");
    a_t3Ctl: assert property (p_t3Ctl)
        else $error("timer3 control not loaded");
    a_vmon: assert property (p_vmon)
        else $error("voltage monitor control not loaded");
    a_port1: assert property (p_port1)
        else $error("port1 write wrong");
    a_aux2: assert property (p_aux2)
        else $error("port2 direction write wrong");
    a_aux5: assert property (p_aux5)
        else $error("port5 control byte wrong");
    a_txLoad: assert property (p_txLoad)
        else $error("tx load without a write");
endmodule : pio_addr_map_chk

bind pio_addr_map pio_addr_map_chk uChk (.*);

// file: dv/pio_core_model.sv
`timescale 1ns/100ps
module pio_core_model (
    // clock
    input wire logic core_clk,
    // bus towards the block
    output logic ioWrStb,
    output logic ioRdStb,
    output logic [3:0] ioAddr,
    output logic [3:0] ioWrData,
    input wire logic [3:0] ioRdData,
    input wire logic ioRdValid
);
    // quiet bus from time zero
    initial {ioWrStb, ioRdStb, ioAddr, ioWrData} = 10'h000;
    // strobe left up so nibbles can run back to back
    task automatic doOut(input logic [3:0] a, input logic [3:0] d);
        ioWrStb <= 1'b1;
        ioRdStb <= 1'b0;
        ioAddr <= a;
        ioWrData <= d;
        @(posedge core_clk);
    endtask : doOut
    // answer one edge after the request, x if none
    task automatic doIn(input logic [3:0] a, output logic [3:0] d);
        ioRdStb <= 1'b1;
        ioWrStb <= 1'b0;
        ioAddr <= a;
        ioWrData <= ~ioWrData;
        @(posedge core_clk);
        ioRdStb <= 1'b0;
        ioAddr <= ~ioAddr;
        @(posedge core_clk);
        d = (ioRdValid === 1'b1) ? ioRdData : 4'hX;
    endtask : doIn
    // idle lines toggle so stale values never pass
    task automatic idle();
        ioWrStb <= 1'b0;
        ioRdStb <= 1'b0;
        ioAddr <= ~ioAddr;
        ioWrData <= ~ioWrData;
        @(posedge core_clk);
    endtask : idle
endmodule : pio_core_model

// file: dv/test_pio_addr_map.sv
`timescale 1ns/100ps
module test_pio_addr_map;
    // clock, reset, pins and peripheral state
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] port1Pins, port2Pins, port4Pins, port5Pins, port6Pins;
    logic [7:0] serRxBuf, t3Capture;
    logic [3:0] serStatus, t3Status;
    // bus and block outputs
    logic ioWrStb, ioRdStb, ioRdValid, port1Drive, wdogKick, serTxLoad;
    logic [3:0] ioAddr, ioWrData, ioRdData, port1Data, port2Data, port2Dir;
    logic [3:0] port4Data, port5Data, port6Data, port6Ctl, sysCfg, clkMgmt;
    logic [3:0] vmonCtl, serCtl1, serStatCtl, serCtl2, t3Ctl;
    logic [7:0] port4Ctl, port5Ctl, serTxBuf;
    logic [7:0] t12Regs [pio_pkg::T12_CNT];
    logic [7:0] t3Regs [pio_pkg::T3_CNT];
    // bookkeeping
    int errors = 0;
    int n_checks = 0;
    logic [3:0] d, e, v;
    logic [7:0] b;
    logic [3:0] adrs [5] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h6};
    pio_addr_map uut (.*);
    pio_core_model core (.*);
    // 125 MHz
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    task automatic chkN(input string nm, input logic [3:0] x,
                        input logic [3:0] s);
        chkB(nm, {4'h0, x}, {4'h0, s});
    endtask : chkN
    task automatic chkB(input string nm, input logic [7:0] x,
                        input logic [7:0] s);
        n_checks++;
        if (s !== x) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, x, s);
        end
    endtask : chkB
    task automatic wr(input logic [3:0] a, input logic [3:0] x);
        core.doOut(a, x);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [3:0] x);
        core.doIn(a, x);
    endtask : rd
    // selector nibble, then low and high nibble of a byte
    task automatic wr3(input logic [3:0] la, input logic [3:0] ld,
                       input logic [3:0] a, input logic [7:0] x);
        wr(la, ld);
        wr(a, x[3:0]);
        wr(a, x[7:4]);
        core.idle();
    endtask : wr3
    task automatic setPins();
        {port1Pins, port2Pins, port4Pins, port5Pins, port6Pins} <=
            20'($urandom);
        {serRxBuf, t3Capture, serStatus, t3Status} <= 24'($urandom);
    endtask : setPins
    // ports 1 and 6 only have bits 0 and 3
    function automatic logic [3:0] msk(input logic [3:0] a);
        return (a == 4'h1 || a == 4'h6) ? 4'h9 : 4'hF;
    endfunction : msk
    function automatic logic [3:0] pins(input logic [3:0] a);
        case (a)
            4'h1: return port1Pins;
            4'h2: return port2Pins;
            4'h4: return port4Pins;
            4'h5: return port5Pins;
            default: return port6Pins;
        endcase
    endfunction : pins
    function automatic logic [3:0] dataOf(input logic [3:0] a);
        case (a)
            4'h1: return port1Data;
            4'h2: return port2Data;
            4'h4: return port4Data;
            4'h5: return port5Data;
            default: return port6Data;
        endcase
    endfunction : dataOf
    task automatic give_verdict();
        if (errors == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict
    // hang guard, far beyond the under two hundred cycles needed
    initial begin
        repeat (5000) @(posedge core_clk);
        errors++;
        give_verdict();
    end
    initial begin
        {port1Pins, port2Pins, port4Pins, port5Pins, port6Pins} = 20'h0;
        {serRxBuf, t3Capture, serStatus, t3Status} = 24'h0;
        void'($urandom(26850));
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge core_clk);
        chkN("port1Data", 4'h9, port1Data);
        chkN("port2Data", 4'hF, port2Data);
        chkN("port2Dir", 4'hF, port2Dir);
        chkB("port4Ctl", 8'hFF, port4Ctl);
        chkB("port5Ctl", 8'hFF, port5Ctl);
        chkN("port5Data", 4'hF, port5Data);
        chkN("port6Data", 4'h9, port6Data);
        chkB("t2Ctl", 8'h00, t12Regs[0]);
        chkB("t2Cmp2", 8'hFF, t12Regs[5]);
        chkN("t1Ctl2", 4'h7, t12Regs[9][3:0]);
        chkN("serStatCtl", 4'hB, serStatCtl);
        chkB("t3Cmp1", 8'hFF, t3Regs[4]);
        chkN("t3Ctl", 4'h0, t3Ctl);
        chkN("vmonCtl", 4'hF, vmonCtl);
        // primary port data: random writes, then pin reads
        repeat (4) begin
            setPins();
            repeat (4) core.idle();
            foreach (adrs[i]) begin
                d = 4'($urandom);
                wr(adrs[i], d);
                rd(adrs[i], v);
                chkN("portData", d & msk(adrs[i]), dataOf(adrs[i]));
                chkN("pinRead", pins(adrs[i]) & msk(adrs[i]), v);
            end
        end
        // aux nibble, then the same address falls back to primary
        d = 4'($urandom);
        e = 4'($urandom);
        wr(4'h8, 4'h2);
        wr(4'h2, d);
        wr(4'h2, e);
        core.idle();
        chkN("port2Dir", d, port2Dir);
        chkN("port2Data", e, port2Data);
        // system config primary, clock management aux, kick on read
        wr(4'h3, d);
        wr(4'h8, 4'h3);
        wr(4'h3, e);
        rd(4'h3, v);
        chkN("sysCfg", d, sysCfg);
        chkN("clkMgmt", e, clkMgmt);
        chkN("wdogKick", 4'h1, 4'(wdogKick));
        b = 8'($urandom);
        wr3(4'h8, 4'h4, 4'h4, b);
        chkB("port4Ctl", b, port4Ctl);
        wr3(4'h8, 4'h5, 4'h5, ~b);
        chkB("port5Ctl", ~b, port5Ctl);
        // timer 1/2 bank, reserved 6 and 7 must stay clear
        for (int s = 0; s < 11; s++) begin
            d = 4'($urandom);
            if (s != 5) begin
                wr(4'h7, 4'(s));
                wr(4'h7, d);
                core.idle();
                chkN("timer12_subport_data", (s == 6 || s == 7) ? 4'h0 : d,
                     t12Regs[s][3:0]);
            end
        end
        wr3(4'h7, 4'h5, 4'h7, b);
        chkB("t2Cmp2", b, t12Regs[5]);
        // timer 3 bank
        for (int s = 0; s < 4; s++) begin
            d = 4'($urandom);
            wr(4'hB, 4'(s));
            wr(4'hB, d);
            core.idle();
            chkN("timer3_subport_data", d, t3Regs[s][3:0]);
        end
        wr3(4'hB, 4'h4, 4'hB, b);
        chkB("t3Cmp1", b, t3Regs[4]);
        wr(4'hB, 4'h7);
        wr(4'hB, d);
        core.idle();
        chkB("t3Cmp2", 8'hFF, t3Regs[5]);
        wr(4'hB, 4'h4);
        rd(4'hB, v);
        chkN("t3CapLo", t3Capture[3:0], v);
        rd(4'hB, v);
        chkN("t3CapHi", t3Capture[7:4], v);
        // serial buffers and status
        wr(4'h9, b[3:0]);
        wr(4'h9, b[7:4]);
        core.idle();
        chkN("serTxLoad", 4'h1, 4'(serTxLoad));
        chkB("serTxBuf", b, serTxBuf);
        rd(4'h9, v);
        chkN("rxLo", serRxBuf[3:0], v);
        rd(4'h9, v);
        chkN("rxHi", serRxBuf[7:4], v);
        rd(4'hA, v);
        chkN("serStatus", serStatus, v);
        wr(4'hA, d);
        core.idle();
        chkN("serStatCtl", d, serStatCtl);
        // timer 3 control and status, voltage monitor
        wr(4'hC, ~d);
        core.idle();
        chkN("t3Ctl", ~d, t3Ctl);
        rd(4'hC, v);
        chkN("t3Status", {1'b0, t3Status[2:0]}, v);
        wr(4'hF, d);
        core.idle();
        chkN("vmonCtl", d, vmonCtl);
        rd(4'hF, v);
        chkN("vmonRead", 4'h0, v);
        give_verdict();
    end
endmodule : test_pio_addr_map
